// ---- rtl/sbc_consts.vh ----
/*
 * Constants for the bus sideband control block: register offsets,
 * field positions, reset values and the pin-input vector layout.
 * Assumes inclusion by the sideband design files only.
 */
`ifndef SBC_CONSTS_VH
`define SBC_CONSTS_VH

// register byte offsets
`define SBC_OFF_CTRL 12'h000
`define SBC_OFF_STAT 12'h004

// control fields
`define SBC_CTRL_NUM_ERR_BIT 0
`define SBC_CTRL_EWB_IGN_BIT 3
`define SBC_CTRL_RST 32'h0000_0000

// status fields
`define SBC_ST_FP_PEND 0
`define SBC_ST_FP_ERR 1
`define SBC_ST_FP_WAIT 2
`define SBC_ST_DRAIN 3
`define SBC_ST_GRANT 4
`define SBC_ST_HIT 5
`define SBC_ST_DIRTY 6
`define SBC_ST_PURGE_LAT 7
`define SBC_ST_TEST 8
`define SBC_ST_PSTATE 9

// synchronised pin vector layout
`define SBC_PIN_N 10
`define SBC_PIN_BURST_RDY_N 0
`define SBC_PIN_SNOOP_N 1
`define SBC_PIN_DRAIN_N 2
`define SBC_PIN_HOLD 3
`define SBC_PIN_IGN_N 4
`define SBC_PIN_PURGE_N 5
`define SBC_PIN_RESET 6
`define SBC_PIN_IRQ 7
`define SBC_PIN_MGMT_N 8
`define SBC_PIN_NMI 9
`define SBC_PIN_RST 10'h137

`endif

// ---- rtl/sbc_pin_sync.v ----
/*
 * Three-stage synchroniser for a vector of pin inputs.
 * A bit's output changes only once stages two and three agree.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module sbc_pin_sync #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // pins in, filtered levels out
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
            q <= RST;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            // take the level where the two agree, else keep the old one
            q <= (s2 & s3) | (q & (s2 | s3));
        end
    end
endmodule

// ---- rtl/sbc_sideband.v ----
/*
 * Bus sideband control: write-buffer throttle, bus hold and grant,
 * inquire hit reporting, cache purge request with float-test strap,
 * floating-point error reporting, plus an APB register slave.
 * Assumes the core supplies same-clock cycle and instruction events;
 * pins from the chipset arrive asynchronous and, except warm_restart, are synchronised.
 */
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "sbc_consts.vh"

module sbc_sideband (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // pins from system logic
    input wire burst_ready_n,
    input wire snoop_addr_strobe_n,
    input wire ext_write_buffer_drained_n,
    input wire bus_hold_req,
    input wire fp_exception_ignore_n,
    input wire cache_purge_n,
    input wire sys_reset,
    input wire maskable_irq,
    input wire sys_mgmt_irq_n,
    input wire nmi_in,
    input wire warm_restart,
    // pins to system logic
    output reg fp_error_out_n,
    output reg bus_yield_grant,
    output reg inquire_hit_n,
    output reg inquire_match_dirty_n,
    output reg bus_float_en,
    output reg float_test_mode,
    // core bus-cycle status
    input wire cyc_active,
    input wire cyc_last_beat,
    input wire cyc_drain_sample,
    input wire cyc_is_writeback,
    input wire cyc_locked,
    // core snoop lookup
    input wire snoop_line_valid,
    input wire snoop_line_dirty,
    input wire snoop_line_wb_busy,
    // core instruction events
    input wire inst_boundary,
    input wire fp_target,
    input wire fp_target_sensitive,
    input wire fp_unmasked_exc,
    input wire fp_env_clear,
    input wire fp_env_load_clear,
    // core purge handshake
    input wire purge_step_done,
    // core controls
    output reg drain_hold_off,
    output reg snoop_wb_start,
    output reg fp_wait,
    output reg fp_proceed,
    output reg fp_vector10,
    output reg purge_wb_req,
    output reg purge_inv_req,
    output reg purge_ack_req
);
    localparam [1:0] P_IDLE = 2'b00;
    localparam [1:0] P_WB = 2'b01;
    localparam [1:0] P_INV = 2'b10;
    localparam [1:0] P_ACK = 2'b11;

    wire [`SBC_PIN_N-1:0] pin_raw;
    wire [`SBC_PIN_N-1:0] pin;
    reg [31:0] ctrl;
    reg drain_wait;
    reg fp_pending;
    reg purge_prev;
    reg purge_latched;
    reg reset_prev;
    reg [1:0] pstate;
    reg [1:0] next_pstate;
    reg next_grant;
    reg [31:0] next_rdata;
    reg next_err;

    wire burst_rdy = ~pin[`SBC_PIN_BURST_RDY_N];
    wire snoop_seen = ~pin[`SBC_PIN_SNOOP_N];
    wire drained = ~pin[`SBC_PIN_DRAIN_N];
    wire hold = pin[`SBC_PIN_HOLD];
    wire ignore = ~pin[`SBC_PIN_IGN_N];
    wire purge = pin[`SBC_PIN_PURGE_N];
    wire rst_in = pin[`SBC_PIN_RESET];
    wire any_irq = pin[`SBC_PIN_IRQ] | ~pin[`SBC_PIN_MGMT_N] | pin[`SBC_PIN_NMI]
        | warm_restart;
    wire num_err_bit = ctrl[`SBC_CTRL_NUM_ERR_BIT];
    wire drain_ignore = ctrl[`SBC_CTRL_EWB_IGN_BIT];
    wire reset_fall = reset_prev & ~rst_in;
    wire last_beat = burst_rdy & cyc_last_beat;
    wire wr_en = psel & penable & pwrite & pready;
    wire setup = psel & ~penable;

    assign pin_raw = {nmi_in, sys_mgmt_irq_n, maskable_irq, sys_reset, cache_purge_n,
        fp_exception_ignore_n, bus_hold_req, ext_write_buffer_drained_n,
        snoop_addr_strobe_n, burst_ready_n};

    // async pins except warm_restart take the same three-stage path
    sbc_pin_sync #(
        .W(`SBC_PIN_N),
        .RST(`SBC_PIN_RST)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pin_raw),
        .q(pin)
    );

    function is_offset;
        input [11:0] a;
        input [11:0] off;
        begin
            is_offset = (a[11:2] == off[11:2]);
        end
    endfunction

    // apb read mux and decode
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (is_offset(paddr, `SBC_OFF_CTRL)) begin
            next_rdata = ctrl;
        end else if (is_offset(paddr, `SBC_OFF_STAT)) begin
            next_rdata[`SBC_ST_FP_PEND] = fp_pending;
            next_rdata[`SBC_ST_FP_ERR] = ~fp_error_out_n;
            next_rdata[`SBC_ST_FP_WAIT] = fp_wait;
            next_rdata[`SBC_ST_DRAIN] = drain_wait;
            next_rdata[`SBC_ST_GRANT] = bus_yield_grant;
            next_rdata[`SBC_ST_HIT] = ~inquire_hit_n;
            next_rdata[`SBC_ST_DIRTY] = ~inquire_match_dirty_n;
            next_rdata[`SBC_ST_PURGE_LAT] = purge_latched;
            next_rdata[`SBC_ST_TEST] = float_test_mode;
            next_rdata[`SBC_ST_PSTATE+1:`SBC_ST_PSTATE] = pstate;
        end else begin
            next_err = 1'b1;
        end
    end

    // one wait-free access phase: answer ready on the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl <= `SBC_CTRL_RST;
        end else begin
            pready <= setup;
            pslverr <= setup & next_err;
            prdata <= (setup & ~pwrite) ? next_rdata : 32'h0000_0000;
            if (wr_en & is_offset(paddr, `SBC_OFF_CTRL)) begin
                ctrl <= 32'h0000_0000;
                ctrl[`SBC_CTRL_NUM_ERR_BIT] <= pwdata[`SBC_CTRL_NUM_ERR_BIT];
                ctrl[`SBC_CTRL_EWB_IGN_BIT] <= pwdata[`SBC_CTRL_EWB_IGN_BIT];
            end
        end
    end

    // write-buffer throttle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drain_wait <= 1'b0;
            drain_hold_off <= 1'b0;
        end else if (drain_ignore) begin
            drain_wait <= 1'b0;
            drain_hold_off <= 1'b0;
        end else if (drain_wait) begin
            // resampled every clock while negated; ignored again once drained
            if (drained) begin
                drain_wait <= 1'b0;
                drain_hold_off <= 1'b0;
            end
        end else if (burst_rdy & cyc_drain_sample) begin
            drain_wait <= ~drained;
            drain_hold_off <= ~drained;
        end
    end

    // bus yield: grant and float flops share the same next value
    always @* begin
        next_grant = bus_yield_grant;
        if (!hold) begin
            next_grant = 1'b0;
        end else if (!bus_yield_grant && !cyc_locked) begin
            if (!cyc_active || last_beat) begin
                next_grant = 1'b1;
            end
        end
    end

    // no reset but the apb reset clears grant, so hold works through sys_reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_yield_grant <= 1'b0;
            bus_float_en <= 1'b0;
        end else begin
            bus_yield_grant <= next_grant;
            bus_float_en <= next_grant;
        end
    end

    // inquire response
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inquire_hit_n <= 1'b1;
            inquire_match_dirty_n <= 1'b1;
            snoop_wb_start <= 1'b0;
        end else begin
            snoop_wb_start <= 1'b0;
            if (snoop_seen && inquire_match_dirty_n) begin
                // strobe ignored while dirty is shown
                inquire_hit_n <= ~snoop_line_valid;
                inquire_match_dirty_n <= ~snoop_line_dirty;
                snoop_wb_start <= snoop_line_dirty & ~snoop_line_wb_busy;
            end else if (!inquire_match_dirty_n && cyc_is_writeback && last_beat) begin
                inquire_match_dirty_n <= 1'b1;
            end
        end
    end

    // floating-point error tracking
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fp_pending <= 1'b0;
            fp_error_out_n <= 1'b1;
            fp_wait <= 1'b0;
            fp_proceed <= 1'b0;
            fp_vector10 <= 1'b0;
            reset_prev <= 1'b0;
        end else begin
            reset_prev <= rst_in;
            fp_proceed <= 1'b0;
            fp_vector10 <= 1'b0;
            if (fp_unmasked_exc) begin
                fp_pending <= 1'b1;
            end else if (fp_env_clear || fp_env_load_clear || reset_fall) begin
                fp_pending <= 1'b0;
            end
            if (fp_env_clear || fp_env_load_clear || reset_fall) begin
                fp_error_out_n <= 1'b1;
            end else if (inst_boundary && fp_target && fp_pending) begin
                fp_error_out_n <= 1'b0;
            end
            if (fp_wait) begin
                // level sampled each clock; any release ends the stall
                if (ignore) begin
                    fp_wait <= 1'b0;
                    fp_proceed <= 1'b1;
                end else if (any_irq) begin
                    fp_wait <= 1'b0;
                end
            end else if (inst_boundary && fp_target) begin
                if (!fp_pending || !fp_target_sensitive) begin
                    fp_proceed <= 1'b1;
                end else if (num_err_bit) begin
                    fp_vector10 <= 1'b1;
                end else if (ignore) begin
                    fp_proceed <= 1'b1;
                end else begin
                    fp_wait <= 1'b1;
                end
            end
        end
    end

    // strap and purge latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            purge_prev <= 1'b1;
            purge_latched <= 1'b0;
            float_test_mode <= 1'b0;
        end else begin
            purge_prev <= purge;
            if (reset_fall) begin
                // value from the edge before reset was seen negated
                float_test_mode <= ~purge_prev;
                purge_latched <= 1'b0;
            end else if (!rst_in && !float_test_mode) begin
                if (purge_prev && !purge) begin
                    purge_latched <= 1'b1;
                end else if (pstate == P_IDLE && inst_boundary) begin
                    purge_latched <= 1'b0;
                end
            end
        end
    end

    // purge sequence: writeback, invalidate, then acknowledge cycle
    always @* begin
        next_pstate = pstate;
        case (pstate)
            P_IDLE: begin
                if (purge_latched && inst_boundary) begin
                    next_pstate = P_WB;
                end
            end
            P_WB: begin
                if (purge_step_done) begin
                    next_pstate = P_INV;
                end
            end
            P_INV: begin
                if (purge_step_done) begin
                    next_pstate = P_ACK;
                end
            end
            P_ACK: begin
                if (purge_step_done) begin
                    next_pstate = P_IDLE;
                end
            end
            default: begin
                next_pstate = P_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pstate <= P_IDLE;
            purge_wb_req <= 1'b0;
            purge_inv_req <= 1'b0;
            purge_ack_req <= 1'b0;
        end else begin
            pstate <= next_pstate;
            purge_wb_req <= (next_pstate == P_WB);
            purge_inv_req <= (next_pstate == P_INV);
            purge_ack_req <= (next_pstate == P_ACK);
        end
    end
endmodule

// ---- testbench/sbc_chipset_model.sv ----
/*
 * Chipset side of the sideband pins.
 * Assumes the bench holds each request level two clocks or more.
 */
`timescale 1ns/1ps
module sbc_chipset_model (
    // clock and device grant
    input wire pclk,
    input wire bus_yield_grant,
    // bench requests
    input wire hold_cmd,
    input wire snoop_cmd,
    input wire ign_cmd,
    input wire purge_cmd,
    input wire full_cmd,
    // pins to the device
    output logic bus_hold_req = 1'h0,
    output logic snoop_addr_strobe_n = 1'h1,
    output logic fp_exception_ignore_n = 1'h1,
    output logic cache_purge_n = 1'h1,
    output logic ext_write_buffer_drained_n = 1'h0
);
    always @(posedge pclk) begin
        bus_hold_req <= hold_cmd;
        // only once the bus has been handed over
        snoop_addr_strobe_n <= !(snoop_cmd && bus_yield_grant);
        fp_exception_ignore_n <= !ign_cmd;
        cache_purge_n <= !purge_cmd;
        ext_write_buffer_drained_n <= full_cmd;
    end
endmodule

// ---- testbench/sbc_sideband_properties.sv ----
/*
 * Port checks for the sideband block.
 * Assumes a bind into sbc_sideband; one clock, async low reset.
 */
`timescale 1ns/1ps
module sbc_sideband_props (
    // clock, reset, bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    // hold and inquire
    input wire bus_hold_req,
    input wire bus_yield_grant,
    input wire bus_float_en,
    input wire snoop_addr_strobe_n,
    input wire inquire_hit_n,
    input wire inquire_match_dirty_n,
    input wire snoop_wb_start,
    // core cycle status
    input wire cyc_active,
    input wire cyc_last_beat,
    input wire cyc_is_writeback,
    input wire cyc_locked,
    // floating point
    input wire inst_boundary,
    input wire fp_target,
    input wire fp_env_clear,
    input wire fp_error_out_n,
    input wire fp_wait,
    input wire fp_exception_ignore_n,
    // purge
    input wire purge_step_done,
    input wire purge_wb_req,
    input wire purge_inv_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_apb_ready; psel && !penable |=> pready; endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
    property p_float; bus_float_en == bus_yield_grant; endproperty
    a_float: assert property (p_float) else $error("float differs from grant");
    // pins pass a synchroniser, so allow six samples
    property p_grant_up; (bus_hold_req && !cyc_active && !cyc_locked) [*6] |-> bus_yield_grant;
    endproperty
    a_grant_up: assert property (p_grant_up) else $error("idle hold not granted");
    property p_grant_dn; (!bus_hold_req) [*6] |-> !bus_yield_grant; endproperty
    a_grant_dn: assert property (p_grant_dn) else $error("grant kept");
    property p_grant_lock; $rose(bus_yield_grant) |-> !$past(cyc_locked); endproperty
    a_grant_lock: assert property (p_grant_lock) else $error("grant in lock");
    property p_hit_cause; $changed(inquire_hit_n) |->
        !$past(snoop_addr_strobe_n, 3) || !$past(snoop_addr_strobe_n, 4); endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit moved alone");
    property p_dirty_hold; !inquire_match_dirty_n && !(cyc_is_writeback && cyc_last_beat)
        |=> !inquire_match_dirty_n; endproperty
    a_dirty_hold: assert property (p_dirty_hold) else $error("dirty dropped early");
    property p_wb_once; snoop_wb_start |-> $fell(inquire_match_dirty_n) ##1 !snoop_wb_start;
    endproperty
    a_wb_once: assert property (p_wb_once) else $error("stray writeback start");
    property p_fp_error_out_set; $fell(fp_error_out_n) |-> $past(inst_boundary && fp_target);
    endproperty
    a_fp_error_out_set: assert property (p_fp_error_out_set) else $error("error off boundary");
    property p_fp_error_out_clr; fp_env_clear && !(inst_boundary && fp_target) |=> fp_error_out_n;
    endproperty
    a_fp_error_out_clr: assert property (p_fp_error_out_clr) else $error("error not cleared");
    property p_wait_ign; fp_wait && !fp_exception_ignore_n |-> ##[1:6] !fp_wait; endproperty
    a_wait_ign: assert property (p_wait_ign) else $error("wait ignores ignore");
    property p_purge_seq; $rose(purge_inv_req) |-> $past(purge_wb_req && purge_step_done);
    endproperty
    a_purge_seq: assert property (p_purge_seq) else $error("purge out of order");
endmodule

bind sbc_sideband sbc_sideband_props u_props (.*);

// ---- testbench/tb_sbc_sideband.sv ----
/*
 * Bench for the sideband block: register rows, then hold, inquire,
 * fp, drain, purge and strap cases. Assumes the chipset model.
 */
`timescale 1ns/1ps
module tb_sbc_sideband;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } sbc_row_t;
    logic pclk = 1'h0, presetn = 1'h0, sys_reset = 1'h1, burst_ready_n = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, q;
    logic cyc_active = 1'h0, cyc_last_beat = 1'h0, cyc_drain_sample = 1'h0;
    logic cyc_is_writeback = 1'h0, cyc_locked = 1'h0, snoop_line_valid = 1'h0;
    logic snoop_line_dirty = 1'h0, snoop_line_wb_busy = 1'h0, inst_boundary = 1'h0;
    logic fp_target = 1'h0, fp_target_sensitive = 1'h0, fp_unmasked_exc = 1'h0;
    logic fp_env_clear = 1'h0, purge_step_done = 1'h0, fp_env_load_clear = 1'h0;
    logic maskable_irq = 1'h0, sys_mgmt_irq_n = 1'h1, nmi_in = 1'h0, warm_restart = 1'h0;
    logic hold_cmd = 1'h0, snoop_cmd = 1'h0, ign_cmd = 1'h0, purge_cmd = 1'h0;
    logic full_cmd = 1'h0;
    wire [31:0] prdata;
    wire pready, pslverr, fp_error_out_n, bus_yield_grant, inquire_hit_n;
    wire inquire_match_dirty_n, bus_float_en, float_test_mode, drain_hold_off;
    wire snoop_wb_start, fp_wait, fp_proceed, fp_vector10, purge_wb_req;
    wire purge_inv_req, purge_ack_req, bus_hold_req, snoop_addr_strobe_n;
    wire fp_exception_ignore_n, cache_purge_n, ext_write_buffer_drained_n;
    int err_count = 0, n_compared = 0, n_wb = 0, n_go = 0, n_v10 = 0;
    wire [9:0] obs = {float_test_mode, purge_ack_req, purge_inv_req, purge_wb_req,
        fp_wait, drain_hold_off, !fp_error_out_n, !inquire_hit_n,
        !inquire_match_dirty_n, bus_yield_grant};
    sbc_row_t rows [8] = '{
        '{1'h0, 12'h000, 32'h0, 32'h0, 1'h0},
        '{1'h1, 12'h000, 32'hFFFFFFFF, 32'h0, 1'h0},
        '{1'h0, 12'h000, 32'h0, 32'h9, 1'h0},
        '{1'h1, 12'h004, 32'hFFFFFFFF, 32'h0, 1'h0},
        '{1'h0, 12'h004, 32'h0, 32'h0, 1'h0},
        '{1'h0, 12'h008, 32'h0, 32'h0, 1'h1},
        '{1'h1, 12'hFFC, 32'h5, 32'h0, 1'h1},
        '{1'h1, 12'h000, 32'h0, 32'h0, 1'h0}
    };

    sbc_sideband dut (.*);
    sbc_chipset_model u_chipset (.*);

    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        n_wb <= n_wb + snoop_wb_start;
        n_go <= n_go + fp_proceed;
        n_v10 <= n_v10 + fp_vector10;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic see(input int k, input logic v);
        @(negedge pclk);
        chk(obs[k], v);
        @(posedge pclk);
    endtask
    task automatic wt(input int k, input logic v);
        int i;
        @(negedge pclk);
        for (i = 0; i < 40 && obs[k] !== v; i++) @(negedge pclk);
        chk(obs[k], v);
        if (obs[k] !== v) conclude;
        @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        // values seen here are those sampled at this rising edge
        for (i = 0; i < 20 && pready !== 1'h1; i++) @(posedge pclk);
        q = prdata;
        e = pslverr;
        chk(pready, 1'h1);
        if (pready !== 1'h1) conclude;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic pulse(input logic [3:0] m);
        {fp_unmasked_exc, inst_boundary, fp_env_clear, purge_step_done} <= m;
        @(posedge pclk);
        {fp_unmasked_exc, inst_boundary, fp_env_clear, purge_step_done} <= 4'h0;
        @(posedge pclk);
    endtask
    task automatic snoop(input logic v, input logic dt, input logic b);
        {snoop_line_valid, snoop_line_dirty, snoop_line_wb_busy} <= {v, dt, b};
        snoop_cmd <= 1'h1;
        cyc(3);
        snoop_cmd <= 1'h0;
        cyc(8);
    endtask
    task automatic wbend;
        {cyc_active, cyc_is_writeback, cyc_last_beat, burst_ready_n} <= 4'hE;
        wt(1, 1'h0);
        {cyc_active, cyc_is_writeback, cyc_last_beat, burst_ready_n} <= 4'h1;
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        cyc(3);
        sys_reset <= 1'h0;
        cyc(8);
        see(0, 1'h0);
        chk({float_test_mode, fp_error_out_n, inquire_hit_n, inquire_match_dirty_n}, 4'h7);
        $display("done reset");
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(q, rows[i].q);
            chk(e, rows[i].e);
        end
        $display("done registers");
        {cyc_active, cyc_locked, hold_cmd} <= 3'h7;
        cyc(10);
        see(0, 1'h0);
        {cyc_active, cyc_locked} <= 2'h0;
        wt(0, 1'h1);
        snoop(1'h1, 1'h1, 1'h0);
        see(2, 1'h1);
        chk(obs[1], 1'h1);
        chk(n_wb, 1);
        snoop(1'h1, 1'h1, 1'h0);
        chk(n_wb, 1);
        wbend;
        snoop(1'h1, 1'h1, 1'h1);
        see(1, 1'h1);
        chk(n_wb, 1);
        wbend;
        snoop(1'h1, 1'h0, 1'h0);
        see(1, 1'h0);
        see(2, 1'h1);
        snoop(1'h0, 1'h0, 1'h0);
        see(2, 1'h0);
        hold_cmd <= 1'h0;
        wt(0, 1'h0);
        $display("done hold and inquire");
        pulse(4'h8);
        cyc(6);
        see(3, 1'h0);
        {fp_target, fp_target_sensitive} <= 2'h3;
        pulse(4'h4);
        wt(3, 1'h1);
        see(5, 1'h1);
        ign_cmd <= 1'h1;
        wt(5, 1'h0);
        ign_cmd <= 1'h0;
        see(3, 1'h1);
        chk(n_go, 1);
        cyc(6);
        pulse(4'h4);
        wt(5, 1'h1);
        nmi_in <= 1'h1;
        wt(5, 1'h0);
        nmi_in <= 1'h0;
        chk(n_go, 1);
        pulse(4'h2);
        wt(3, 1'h0);
        apb(1'h1, 12'h000, 32'h1);
        pulse(4'h8);
        pulse(4'h4);
        cyc(3);
        chk(n_v10, 1);
        fp_target_sensitive <= 1'h0;
        pulse(4'h4);
        cyc(3);
        chk(n_go, 2);
        see(3, 1'h1);
        fp_env_load_clear <= 1'h1;
        cyc(1);
        fp_env_load_clear <= 1'h0;
        wt(3, 1'h0);
        $display("done fp");
        apb(1'h1, 12'h000, 32'h0);
        full_cmd <= 1'h1;
        {cyc_active, cyc_drain_sample, burst_ready_n} <= 3'h6;
        wt(4, 1'h1);
        {cyc_active, cyc_drain_sample, burst_ready_n} <= 3'h1;
        full_cmd <= 1'h0;
        wt(4, 1'h0);
        full_cmd <= 1'h1;
        cyc(8);
        see(4, 1'h0);
        apb(1'h1, 12'h000, 32'h8);
        {cyc_active, cyc_drain_sample, burst_ready_n} <= 3'h6;
        cyc(8);
        see(4, 1'h0);
        {cyc_active, cyc_drain_sample, burst_ready_n} <= 3'h1;
        full_cmd <= 1'h0;
        $display("done drain");
        purge_cmd <= 1'h1;
        cyc(3);
        purge_cmd <= 1'h0;
        cyc(6);
        see(6, 1'h0);
        pulse(4'h4);
        wt(6, 1'h1);
        pulse(4'h1);
        wt(7, 1'h1);
        pulse(4'h1);
        wt(8, 1'h1);
        pulse(4'h1);
        wt(8, 1'h0);
        $display("done purge");
        {sys_reset, purge_cmd, hold_cmd} <= 3'h7;
        wt(0, 1'h1);
        sys_reset <= 1'h0;
        cyc(6);
        {purge_cmd, hold_cmd} <= 2'h0;
        wt(9, 1'h1);
        $display("done strap");
        conclude;
    end
endmodule
